// ==== hw/analog_chan_if.sv ====
// Interface carrying one analog channel between selector and conditioner.
`timescale 1ns/100ps
`default_nettype none
interface analog_chan_if;
  import freq_ref_pkg::*;
  pct_t       sample;
  pct_t       offset;
  logic [3:0] filt_shift;
  logic       bipolar;
  logic       tick;
  pct_t       result;
  modport owner (output sample, output offset, output filt_shift,
                 output bipolar, output tick, input result);
  modport chan  (input sample, input offset, input filt_shift,
                 input bipolar, input tick, output result);
endinterface
`default_nettype wire

// ==== hw/analog_conditioner.sv ====
// Offset, polarity clamp and first-order filter for one analog input.
`timescale 1ns/100ps
`default_nettype none
module analog_conditioner (
  // Clock and reset
  input wire logic  sys_clk,
  input wire logic  reset_n,
  // Channel
  analog_chan_if.chan ch
);
  import freq_ref_pkg::*;

  typedef struct packed {
    logic signed [31:0] acc;
  } cond_state_t;

  cond_state_t state_reg;
  cond_state_t state_next;
  logic signed [31:0] x;

  always_comb begin
    state_next = state_reg;
    x = 32'(ch.sample) + 32'(ch.offset);
    if (x > 32'(PCT_FULL)) x = 32'(PCT_FULL);
    if (x < -32'(PCT_FULL)) x = -32'(PCT_FULL);
    if (!ch.bipolar && x < 0) x = 32'sh0000_0000;
    if (ch.tick) begin
      // Larger shift gives heavier smoothing and slower response.
      state_next.acc = state_reg.acc
        + (((x <<< FILT_FRAC) - state_reg.acc) >>> ch.filt_shift);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) state_reg <= '0;
    else state_reg <= state_next;
  end

  assign ch.result = state_reg.acc[FILT_FRAC+DATA_W-1:FILT_FRAC];
endmodule // analog_conditioner
`default_nettype wire

// ==== hw/freq_ref_pkg.sv ====
// Shared constants, types and scaling arithmetic for the reference selector.
package freq_ref_pkg;

  // ----------------------------------------------------------------------
  // Widths and types
  // ----------------------------------------------------------------------
  localparam int DATA_W   = 16;
  localparam int FILT_FRAC = 16;
  typedef logic signed [DATA_W-1:0] pct_t;   // 0.01 % units
  typedef logic        [DATA_W-1:0] freq_t;  // 0.01 Hz units
  typedef logic signed [DATA_W:0]   sref_t;  // signed reference

  // ----------------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------------
  localparam pct_t        PCT_FULL     = 16'sh2710;
  localparam logic [3:0]  SRC_KEYPAD   = 4'h0;
  localparam logic [3:0]  SRC_VOLT1    = 4'h1;
  localparam logic [3:0]  SRC_CURR     = 4'h2;
  localparam logic [3:0]  SRC_SUM      = 4'h3;
  localparam logic [3:0]  SRC_VOLT2    = 4'h5;
  localparam logic [3:0]  SRC_TERMINAL = 4'h7;
  localparam int          FSW_KEY_BIT  = 1;
  localparam logic        POL_BIPOLAR  = 1'b0;
  localparam logic        INIT_ZERO    = 1'b0;
  localparam freq_t       FREQ_RESET   = 16'h0000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_TIME_NS   = 1_000_000;
  localparam int TICK_CYCLES    = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int SAVE_WINDOW_MS = 3000;
  // Divide first: the product in nanoseconds would overflow a 32-bit int.
  localparam int SAVE_WINDOW_TICKS = SAVE_WINDOW_MS * (1_000_000 / TICK_TIME_NS);

  // Clamp a wide signed value to the legal reference range.
  function automatic sref_t sat_ref(input logic signed [31:0] v,
                                    input freq_t maxf, input logic bip);
    logic signed [31:0] hi;
    logic signed [31:0] lo;
    hi = {16'h0000, maxf};
    lo = bip ? -hi : 32'sh0000_0000;
    if (v > hi) return hi[DATA_W:0];
    if (v < lo) return lo[DATA_W:0];
    return v[DATA_W:0];
  endfunction

  // Map an input through the bias point and gain point to a frequency.
  function automatic logic signed [31:0] scale_point(input pct_t x,
      input pct_t bias, input pct_t bbp, input pct_t gain, input pct_t gbp,
      input freq_t maxf);
    logic signed [31:0] mag;
    logic signed [31:0] pct;
    logic signed [31:0] f;
    mag = (x < 0) ? -32'(x) : 32'(x);
    if (bbp >= gbp) return 32'sh0000_0000;
    if (mag < 32'(bbp)) pct = 32'(bias);
    else pct = 32'(bias) + (32'(gain) - 32'(bias)) * (mag - 32'(bbp))
               / (32'(gbp) - 32'(bbp));
    if (pct > 32'sh0000_4E20) pct = 32'sh0000_4E20;
    if (pct < -32'sh0000_4E20) pct = -32'sh0000_4E20;
    f = pct * $signed({16'h0000, maxf}) / 32'(PCT_FULL);
    return (x < 0) ? -f : f;
  endfunction

endpackage

// ==== hw/frequency_reference_select.sv ====
// Reference frequency selector: keypad, analog inputs and terminal ramp.
//
// Operation
// - Selector 0 takes keypad keys, or the potentiometer when present and chosen.
// - Keypad frequency is stored only if save key comes within 3 s.
// - Switch bit 1 chooses potentiometer (0) or keys (1); default 0.
// - Selectors 1, 2, 3, 5 pick voltage one, current, sum, voltage two.
// - Polarity 0 accepts -10..+10 V; 1 clamps negatives to zero.
// - Summed mode scales each input separately and adds the results.
// - Bias and gain are percent of max frequency; base points of full scale.
// - Inputs below the bias base point give the bias value.
// - Bias base point at or above gain base point forces 0 Hz.
// - Bipolar with zero bias and base point is symmetric about zero.
// - Raise alone accelerates, lower alone decelerates, else hold.
// - Terminal frequency stays between zero and maximum frequency.
// - Initial setting 0 clears terminal frequency on every restart.
// - Initial setting 1 restarts from the last terminal frequency held; the ramp restarts at 0 Hz and accelerates up to it.
// - Each analog input has a first-order filter with its own constant.
// - Each analog input has its own offset before scaling.
// - Negative voltage only on high-power variants; else inputs unipolar.
// - Summed result saturates at maximum frequency.
// - Raise or lower during restart catch-up continues from present value.
`timescale 1ns/100ps
`default_nettype none
module frequency_reference_select #(
  parameter int          TICK_DIV       = freq_ref_pkg::TICK_CYCLES,
  parameter int          SAVE_TICKS     = freq_ref_pkg::SAVE_WINDOW_TICKS,
  parameter logic        HIGH_POWER     = 1'b1,
  parameter logic [15:0] KEY_STEP       = 16'h0001
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // Source selection and limits
  input  wire logic [3:0]           source_sel,
  input  wire logic [15:0]          func_switch,
  input  wire freq_ref_pkg::freq_t  max_freq,
  // Keypad and potentiometer
  input  wire logic                 key_up,
  input  wire logic                 key_down,
  input  wire logic                 save_confirm_key,
  input  wire logic                 pot_present,
  input  wire freq_ref_pkg::pct_t   pot_level,
  // Analog samples, in hundredths of a percent of full scale
  input  wire freq_ref_pkg::pct_t   voltage_input_one,
  input  wire freq_ref_pkg::pct_t   current_input,
  input  wire freq_ref_pkg::pct_t   voltage_input_two,
  // Analog adjustment
  input  wire freq_ref_pkg::pct_t   offset_v1,
  input  wire freq_ref_pkg::pct_t   offset_cur,
  input  wire freq_ref_pkg::pct_t   offset_v2,
  input  wire logic [3:0]           filt_v1,
  input  wire logic [3:0]           filt_cur,
  input  wire logic [3:0]           filt_v2,
  input  wire logic                 polarity_v1,
  input  wire logic                 polarity_v2,
  input  wire freq_ref_pkg::pct_t   bias,
  input  wire freq_ref_pkg::pct_t   bias_base,
  input  wire freq_ref_pkg::pct_t   gain_v1,
  input  wire freq_ref_pkg::pct_t   gain_base_v1,
  input  wire freq_ref_pkg::pct_t   gain_cur,
  input  wire freq_ref_pkg::pct_t   gain_base_cur,
  input  wire freq_ref_pkg::pct_t   gain_v2,
  input  wire freq_ref_pkg::pct_t   gain_base_v2,
  // Terminal raise/lower control
  input  wire logic                 run_cmd,
  input  wire logic                 terminal_raise_cmd,
  input  wire logic                 terminal_lower_cmd,
  input  wire logic                 updown_init_hold,
  input  wire logic [15:0]          accel_ms,
  input  wire logic [15:0]          decel_ms,
  // Nonvolatile store
  input  wire freq_ref_pkg::freq_t  stored_key_freq,
  input  wire freq_ref_pkg::freq_t  stored_held_freq,
  output logic                      key_store_strobe,
  output freq_ref_pkg::freq_t       key_store_value,
  output freq_ref_pkg::freq_t       held_store_value,
  // Results
  output freq_ref_pkg::sref_t       ref_freq,
  output logic                      setting_invalid,
  output logic                      save_indication
);
  import freq_ref_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [5:0]  pin_q;
    logic [31:0] tick_cnt;
    logic        tick;
    logic        init_done;
    freq_t       key_freq;
    logic        save_armed;
    logic [31:0] save_cnt;
    logic        save_ind;
    logic        store_stb;
    freq_t       store_val;
    freq_t       held;
    logic        load;
    freq_t       load_val;
    logic [3:0]  prev_src;
    sref_t       ref_val;
    logic        invalid;
  } sel_state_t;

  sel_state_t state_reg;
  sel_state_t state_next;

  // Synchronised pin copies, in the order packed into sync1.
  localparam int P_UP   = 0;
  localparam int P_DN   = 1;
  localparam int P_SAVE = 2;
  localparam int P_RUN  = 3;
  localparam int P_RAI  = 4;
  localparam int P_LOW  = 5;

  // ----------------------------------------------------------------------
  // Analog conditioning
  // ----------------------------------------------------------------------
  analog_chan_if ch_v1 ();
  analog_chan_if ch_cur ();
  analog_chan_if ch_v2 ();

  // Small variants have no negative input path, so bipolar is refused.
  logic bip_v1;
  logic bip_v2;
  assign bip_v1 = HIGH_POWER && (polarity_v1 == POL_BIPOLAR);
  assign bip_v2 = HIGH_POWER && (polarity_v2 == POL_BIPOLAR);

  assign ch_v1.sample      = voltage_input_one;
  assign ch_v1.offset      = offset_v1;
  assign ch_v1.filt_shift  = filt_v1;
  assign ch_v1.bipolar     = bip_v1;
  assign ch_v1.tick        = state_reg.tick;
  assign ch_cur.sample     = current_input;
  assign ch_cur.offset     = offset_cur;
  assign ch_cur.filt_shift = filt_cur;
  assign ch_cur.bipolar    = 1'b0;
  assign ch_cur.tick       = state_reg.tick;
  assign ch_v2.sample      = voltage_input_two;
  assign ch_v2.offset      = offset_v2;
  assign ch_v2.filt_shift  = filt_v2;
  assign ch_v2.bipolar     = bip_v2;
  assign ch_v2.tick        = state_reg.tick;

  analog_conditioner u_cond_v1 (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .ch      (ch_v1)
  );
  analog_conditioner u_cond_cur (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .ch      (ch_cur)
  );
  analog_conditioner u_cond_v2 (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .ch      (ch_v2)
  );

  // ----------------------------------------------------------------------
  // Terminal raise/lower ramp
  // ----------------------------------------------------------------------
  logic  term_active;
  logic  catching;
  freq_t term_freq;

  assign term_active = (source_sel == SRC_TERMINAL);

  updown_ramp u_ramp (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .tick       (state_reg.tick),
    .active     (term_active),
    .run        (state_reg.pin_q[P_RUN]),
    .raise      (state_reg.pin_q[P_RAI]),
    .lower      (state_reg.pin_q[P_LOW]),
    .init_hold  (updown_init_hold),
    .load       (state_reg.load),
    .load_value (state_reg.load_val),
    .held_value (state_reg.held),
    .max_freq   (max_freq),
    .accel_ms   (accel_ms),
    .decel_ms   (decel_ms),
    .catching   (catching),
    .freq       (term_freq)
  );

  // ----------------------------------------------------------------------
  // Analog scaling
  // ----------------------------------------------------------------------
  logic signed [31:0] f_v1;
  logic signed [31:0] f_cur;
  logic signed [31:0] f_v2;
  logic signed [31:0] f_pot;
  logic               inv_v1;
  logic               inv_cur;
  logic               inv_v2;

  always_comb begin
    f_v1  = scale_point(ch_v1.result, bias, bias_base, gain_v1,
                        gain_base_v1, max_freq);
    f_cur = scale_point(ch_cur.result, bias, bias_base, gain_cur,
                        gain_base_cur, max_freq);
    f_v2  = scale_point(ch_v2.result, bias, bias_base, gain_v2,
                        gain_base_v2, max_freq);
    f_pot = scale_point(pot_level, 16'sh0000, 16'sh0000, PCT_FULL,
                        PCT_FULL, max_freq);
    inv_v1  = (bias_base >= gain_base_v1);
    inv_cur = (bias_base >= gain_base_cur);
    inv_v2  = (bias_base >= gain_base_v2);
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic        use_pot;
  logic        key_edge_up;
  logic        key_edge_dn;
  logic        save_edge;
  logic [31:0] key_sum;

  always_comb begin
    state_next = state_reg;
    state_next.sync1 = {terminal_lower_cmd, terminal_raise_cmd, run_cmd,
                        save_confirm_key, key_down, key_up};
    state_next.sync2 = state_reg.sync1;
    state_next.pin_q = state_reg.sync2;
    state_next.store_stb = 1'b0;
    state_next.load = 1'b0;
    state_next.init_done = 1'b1;

    key_edge_up = state_reg.sync2[P_UP] && !state_reg.pin_q[P_UP];
    key_edge_dn = state_reg.sync2[P_DN] && !state_reg.pin_q[P_DN];
    save_edge   = state_reg.sync2[P_SAVE] && !state_reg.pin_q[P_SAVE];
    use_pot = pot_present && !func_switch[FSW_KEY_BIT];
    key_sum = 32'(state_reg.key_freq) + 32'(KEY_STEP);

    // Millisecond enable for filters, ramp and the save window.
    if (state_reg.tick_cnt >= 32'(TICK_DIV - 1)) begin
      state_next.tick_cnt = 32'h0000_0000;
      state_next.tick = 1'b1;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 32'h0000_0001;
      state_next.tick = 1'b0;
    end

    // Nonvolatile values are only trusted after the reset is released.
    if (!state_reg.init_done) begin
      state_next.key_freq = (stored_key_freq > max_freq) ? max_freq
                            : stored_key_freq;
      state_next.held = stored_held_freq;
    end

    // Keypad adjustment arms the save window.
    if (state_reg.init_done && source_sel == SRC_KEYPAD && !use_pot) begin
      if (key_edge_up && !key_edge_dn) begin
        state_next.key_freq = (key_sum > 32'(max_freq)) ? max_freq
                              : key_sum[DATA_W-1:0];
        state_next.save_armed = 1'b1;
        state_next.save_cnt = 32'h0000_0000;
        state_next.save_ind = 1'b0;
      end else if (key_edge_dn && !key_edge_up) begin
        state_next.key_freq = (state_reg.key_freq < KEY_STEP) ? FREQ_RESET
                              : state_reg.key_freq - KEY_STEP;
        state_next.save_armed = 1'b1;
        state_next.save_cnt = 32'h0000_0000;
        state_next.save_ind = 1'b0;
      end else if (save_edge && state_reg.save_armed) begin
        state_next.store_stb = 1'b1;
        state_next.store_val = state_reg.key_freq;
        state_next.save_ind = 1'b1;
        state_next.save_armed = 1'b0;
      end else if (state_reg.save_armed && state_reg.tick) begin
        // Window elapsed: the adjusted value stays live but unsaved.
        if (state_reg.save_cnt >= 32'(SAVE_TICKS - 1))
          state_next.save_armed = 1'b0;
        else state_next.save_cnt = state_reg.save_cnt + 32'h0000_0001;
      end
    end

    // Held value tracks terminal frequency once catch-up is over.
    if (state_reg.init_done && term_active && !catching)
      state_next.held = term_freq;

    // With initial setting 0, switching into terminal control starts from the last reference.
    state_next.prev_src = source_sel;
    if (term_active && state_reg.prev_src != SRC_TERMINAL
        && state_reg.init_done && !updown_init_hold) begin
      state_next.load = 1'b1;
      state_next.load_val = (state_reg.ref_val < 0) ? FREQ_RESET
                            : state_reg.ref_val[DATA_W-1:0];
    end

    // Reference mux.
    state_next.invalid = 1'b0;
    case (source_sel)
      SRC_KEYPAD: begin
        state_next.ref_val = use_pot ? sat_ref(f_pot, max_freq, 1'b0)
                             : {1'b0, state_reg.key_freq};
      end
      SRC_VOLT1: begin
        state_next.invalid = inv_v1;
        state_next.ref_val = sat_ref(f_v1, max_freq, bip_v1);
      end
      SRC_CURR: begin
        state_next.invalid = inv_cur;
        state_next.ref_val = sat_ref(f_cur, max_freq, 1'b0);
      end
      SRC_SUM: begin
        state_next.invalid = inv_v1 || inv_cur;
        state_next.ref_val = sat_ref(f_v1 + f_cur, max_freq,
                                     bip_v1);
        if (state_next.invalid) state_next.ref_val = '0;
      end
      SRC_VOLT2: begin
        state_next.invalid = inv_v2;
        state_next.ref_val = sat_ref(f_v2, max_freq, bip_v2);
      end
      SRC_TERMINAL: begin
        state_next.ref_val = {1'b0, term_freq};
      end
      default: begin
        state_next.ref_val = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers and outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) state_reg <= '0;
    else state_reg <= state_next;
  end

  assign ref_freq         = state_reg.ref_val;
  assign setting_invalid  = state_reg.invalid;
  assign save_indication  = state_reg.save_ind;
  assign key_store_strobe = state_reg.store_stb;
  assign key_store_value  = state_reg.store_val;
  assign held_store_value = state_reg.held;

endmodule // frequency_reference_select
`default_nettype wire

// ==== hw/updown_ramp.sv ====
// Terminal raise/lower frequency ramp with restart initial value.
`timescale 1ns/100ps
`default_nettype none
module updown_ramp (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // Control
  input  wire logic                  tick,
  input  wire logic                  active,
  input  wire logic                  run,
  input  wire logic                  raise,
  input  wire logic                  lower,
  input  wire logic                  init_hold,
  input  wire logic                  load,
  input  wire freq_ref_pkg::freq_t   load_value,
  input  wire freq_ref_pkg::freq_t   held_value,
  input  wire freq_ref_pkg::freq_t   max_freq,
  input  wire logic [15:0]           accel_ms,
  input  wire logic [15:0]           decel_ms,
  // Result
  output logic                       catching,
  output freq_ref_pkg::freq_t        freq
);
  import freq_ref_pkg::*;

  typedef struct packed {
    freq_t freq;
    logic  catching;
    logic  run_q;
  } ramp_state_t;

  ramp_state_t state_reg;
  ramp_state_t state_next;
  logic [31:0] up_step;
  logic [31:0] dn_step;
  logic [31:0] sum;

  always_comb begin
    state_next = state_reg;
    state_next.run_q = run;
    up_step = 32'(max_freq) / ((accel_ms == 16'h0000) ? 32'h1 : 32'(accel_ms));
    dn_step = 32'(max_freq) / ((decel_ms == 16'h0000) ? 32'h1 : 32'(decel_ms));
    if (up_step == 32'h0) up_step = 32'h1;
    if (dn_step == 32'h0) dn_step = 32'h1;
    sum = 32'(state_reg.freq) + up_step;
    if (load) begin
      state_next.freq = load_value;
      state_next.catching = 1'b0;
    end else if (active && run && !state_reg.run_q) begin
      state_next.freq = FREQ_RESET;
      state_next.catching = init_hold && (held_value != FREQ_RESET);
    end else if (active && run && tick) begin
      if (state_reg.catching && (raise || lower)) begin
        state_next.catching = 1'b0;
      end else if (state_reg.catching) begin
        if (sum >= 32'(held_value)) begin
          state_next.freq = held_value;
          state_next.catching = 1'b0;
        end else state_next.freq = sum[DATA_W-1:0];
      end else if (raise && !lower) begin
        state_next.freq = (sum > 32'(max_freq)) ? max_freq
                          : sum[DATA_W-1:0];
      end else if (lower && !raise) begin
        state_next.freq = (32'(state_reg.freq) < dn_step) ? FREQ_RESET
                          : state_reg.freq - dn_step[DATA_W-1:0];
      end
    end
    if (state_next.freq > max_freq) state_next.freq = max_freq;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) state_reg <= '0;
    else state_reg <= state_next;
  end

  assign freq = state_reg.freq;
  assign catching = state_reg.catching;
endmodule // updown_ramp
`default_nettype wire

// ==== sim/freq_ref_sva.sv ====
// Assertion checker on the top ports of the reference selector.
`timescale 1ns/100ps
`default_nettype none
module freq_ref_sva
  import freq_ref_pkg::*;
(
  // Watched ports
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic [3:0] source_sel,
  input wire freq_t      max_freq,
  input wire logic       run_cmd,
  input wire logic       terminal_raise_cmd,
  input wire logic       terminal_lower_cmd,
  input wire logic       updown_init_hold,
  input wire logic       key_store_strobe,
  input wire logic       setting_invalid,
  input wire logic       save_indication,
  input wire sref_t      ref_freq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire sref_t top = {1'b0, max_freq};
  // Eight steady cycles cover the pin synchroniser and a restart.
  wire logic upd = source_sel == SRC_TERMINAL && run_cmd && !updown_init_hold;
  wire logic r = terminal_raise_cmd;
  wire logic l = terminal_lower_cmd;
  a_invalid_ref_zero: assert property (setting_invalid[*2] |-> ref_freq == 0)
    else $error("ref not zero while invalid");
  a_ref_below_max: assert property (ref_freq <= top)
    else $error("ref above max");
  a_ref_above_min: assert property (ref_freq >= -top)
    else $error("ref below -max");
  a_term_not_neg: assert property ((source_sel == SRC_TERMINAL)[*4] |-> !ref_freq[16])
    else $error("terminal ref negative");
  a_hold_idle: assert property ((upd && !r && !l)[*8] |-> $stable(ref_freq))
    else $error("ref moved with no command");
  a_hold_both: assert property ((upd && r && l)[*8] |-> $stable(ref_freq))
    else $error("ref moved with both commands");
  a_raise_rises: assert property ((upd && r && !l)[*8] |-> ref_freq >= $past(ref_freq))
    else $error("ref fell on raise");
  a_strobe_pulse: assert property (key_store_strobe |=> !key_store_strobe && save_indication)
    else $error("bad save strobe");
  c_invalid: cover property (setting_invalid);
  c_saved: cover property (key_store_strobe);
  c_term_max: cover property (source_sel == SRC_TERMINAL && ref_freq == top);
endmodule // freq_ref_sva
bind frequency_reference_select freq_ref_sva freq_ref_sva_i (.*);
`default_nettype wire

// ==== sim/key_panel.sv ====
// Operator keypad model: each request holds one key down for a press.
`timescale 1ns/100ps
`default_nettype none
module key_panel (
  // Clock and requests
  input  wire logic       sys_clk,
  input  wire logic [2:0] hit,
  // Key pins
  output logic            key_up,
  output logic            key_down,
  output logic            save_confirm_key
);
  logic [2:0] held_reg = 3'h0;
  logic [3:0] cnt_reg = 4'h0;
  // A press lasts nine cycles so the pin synchroniser cannot miss it.
  always @(posedge sys_clk) begin
    if (hit != 3'h0) begin
      held_reg <= hit;
      cnt_reg <= 4'h8;
    end else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
    else held_reg <= 3'h0;
  end
  assign {save_confirm_key, key_down, key_up} = held_reg;
endmodule // key_panel
`default_nettype wire

// ==== sim/tb_frequency_reference_select.sv ====
// Self-checking bench for the reference frequency selector.
`timescale 1ns/100ps
`default_nettype none
module tb_frequency_reference_select;
  import freq_ref_pkg::*;
  typedef struct packed {logic [3:0] s; pct_t x; sref_t e;} row_t;
  logic sys_clk, reset_n, key_up, key_down, save_confirm_key, pot_present;
  logic polarity_v1, polarity_v2, run_cmd, terminal_raise_cmd;
  logic terminal_lower_cmd, updown_init_hold, key_store_strobe;
  logic setting_invalid, save_indication;
  logic [2:0] hit;
  logic [3:0] source_sel, filt_v1, filt_cur, filt_v2;
  logic [15:0] func_switch, accel_ms, decel_ms;
  freq_t max_freq, stored_key_freq, stored_held_freq, key_store_value;
  freq_t held_store_value;
  pct_t pot_level, voltage_input_one, current_input, voltage_input_two;
  pct_t offset_v1, offset_cur, offset_v2, bias, bias_base, gain_v1;
  pct_t gain_base_v1, gain_cur, gain_base_cur, gain_v2, gain_base_v2;
  sref_t ref_freq;
  int errors, n_checks, n_saves;
  // Bias 5 % at 10 %, gain 100 % at 50 %, max 60 Hz.
  row_t rows [7] = '{'{4'h1, 16'h0BB8, 17'h0_0C4E},
    '{4'h1, 16'h01F4, 17'h0_012C}, '{4'h2, 16'h0BB8, 17'h0_0C4E},
    '{4'h3, 16'h0BB8, 17'h0_1770}, '{4'h5, 16'hF448, 17'h1_F3B2},
    '{4'h1, 16'hF448, 17'h0_012C}, '{4'h4, 16'h0BB8, 17'h0_0000}};
  frequency_reference_select #(.TICK_DIV(10), .SAVE_TICKS(5))
    frequency_reference_select_i (.*);
  key_panel key_panel_i (.sys_clk(sys_clk), .hit(hit), .key_up(key_up),
    .key_down(key_down), .save_confirm_key(save_confirm_key));
  always @(posedge sys_clk) n_saves <= n_saves + int'(key_store_strobe);
  task automatic check(string nm, sref_t got, sref_t exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_n(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic press(logic [2:0] k);
    hit <= k;
    wait_n(1);
    hit <= 3'h0;
    wait_n(20);
  endtask
  task automatic wrap_up;
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ---
  // Stimulus
  // ---
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {hit, reset_n, source_sel, pot_present, pot_level, voltage_input_one,
     current_input, voltage_input_two, offset_v1, offset_cur, offset_v2,
     filt_v1, filt_cur, filt_v2, polarity_v2, run_cmd, terminal_raise_cmd,
     terminal_lower_cmd, updown_init_hold, stored_key_freq,
     stored_held_freq} = '0;
    {polarity_v1, func_switch, max_freq} = {1'b1, 16'h0002, 16'h1770};
    {accel_ms, decel_ms, bias, bias_base} = 64'h000A_000A_01F4_03E8;
    {gain_v1, gain_cur, gain_v2} = {3{16'sh2710}};
    {gain_base_v1, gain_base_cur, gain_base_v2} = {3{16'sh1388}};
    wait_n(8);
    check("ref_in_reset", ref_freq, '0);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      source_sel <= rows[i].s;
      {voltage_input_one, current_input, voltage_input_two} <= {3{rows[i].x}};
      wait_n(40);
      check("analog_ref", ref_freq, rows[i].e);
    end
    {bias_base, source_sel} <= {16'sh1388, 4'h1};
    wait_n(5);
    check("invalid_ref", ref_freq, '0);
    check("invalid_flag", setting_invalid, 17'h0_0001);
    {bias_base, source_sel} <= {16'sh03E8, SRC_TERMINAL};
    {run_cmd, terminal_raise_cmd} <= 2'b11;
    wait_n(150);
    check("raise_to_max", ref_freq, 17'h0_1770);
    check("held_value", held_store_value, 17'h0_1770);
    terminal_lower_cmd <= 1'b1;
    wait_n(40);
    check("both_hold", ref_freq, 17'h0_1770);
    terminal_raise_cmd <= 1'b0;
    wait_n(150);
    check("lower_to_zero", ref_freq, '0);
    {terminal_lower_cmd, terminal_raise_cmd} <= 2'b01;
    wait_n(40);
    {run_cmd, terminal_raise_cmd} <= 2'b00;
    wait_n(10);
    run_cmd <= 1'b1;
    wait_n(20);
    check("restart_zero", ref_freq, '0);
    source_sel <= SRC_KEYPAD;
    press(3'h1);
    press(3'h1);
    press(3'h4);
    check("key_ref", ref_freq, 17'h0_0002);
    check("key_saved", key_store_value, 17'h0_0002);
    check("save_shown", save_indication, 17'h0_0001);
    check("save_strobes", n_saves, 17'h0_0001);
    {pot_present, pot_level, func_switch} <= {1'b1, 16'sh1388, 16'h0000};
    wait_n(5);
    check("pot_ref", ref_freq, 17'h0_0BB8);
    wrap_up;
  end
  initial begin
    wait_n(3000);
    errors++;
    wrap_up;
  end
endmodule // tb_frequency_reference_select
`default_nettype wire
